// ---- logic/lcg_pkg.sv ----
// constants and types for the logic cell gate-select stage
// assumes a classic wishbone master with 32-bit data on the system clock
//
// What this block does
// - gate one select bits include data inputs, bit 7 in4 true down to bit 0 in1 negated
// - gate two select register uses the same ordering; set bit includes, cleared excludes
// - gate three includes a data input form only while its select bit is set
// - gate four includes a data input form only while its select bit is set
// - gate select bits unknown at power-on, kept through other resets, read and write
// - unimplemented polarity and input-select bits ignore writes and read zero
// - each data input picks one of eight sources by a three-bit binary index
package lcg_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] LCG_ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] LCG_ADDR_POLARITY = 8'h04;
  localparam logic [7:0] LCG_ADDR_SRC_ONE  = 8'h08;
  localparam logic [7:0] LCG_ADDR_SRC_TWO  = 8'h0c;
  localparam logic [7:0] LCG_ADDR_GATE_ONE = 8'h10;
  localparam logic [7:0] LCG_ADDR_GATE_TWO = 8'h14;
  localparam logic [7:0] LCG_ADDR_GATE_THR = 8'h18;
  localparam logic [7:0] LCG_ADDR_GATE_FOU = 8'h1c;
  localparam logic [7:0] LCG_ADDR_STATUS   = 8'h20;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam logic [7:0] LCG_POL_MASK      = 8'h8f;
  localparam logic [7:0] LCG_SEL_MASK      = 8'h77;
  localparam logic [7:0] LCG_CTRL_MASK     = 8'hdf;
  localparam logic [7:0] LCG_CTRL_RESET    = 8'h00;
  localparam logic [7:0] LCG_POL_RESET     = 8'h00;
  localparam logic [7:0] LCG_SRC_RESET     = 8'h00;
  localparam int         LCG_SEL_LO_POS    = 0;
  localparam int         LCG_SEL_HI_POS    = 4;
  localparam int         LCG_SEL_W         = 3;
  localparam int         LCG_CTRL_EN_POS   = 7;
  localparam int         LCG_CTRL_FN_W     = 3;
  localparam int         LCG_NUM_GATES     = 4;
  localparam int         LCG_NUM_SOURCES   = 8;

  typedef struct packed {
    logic [3:0] gate;
    logic [3:0] data;
  } lcg_status_type;

  typedef enum logic [1:0] {
    LCG_IDLE = 2'b01,
    LCG_ACK  = 2'b10
  } lcg_bus_state_type;

endpackage : lcg_pkg

// ---- logic/lcg_src_mux.sv ----
// one data input: picks one of eight cell input sources
// assumes sources already synchronised to clock
`timescale 1ns/100ps
`default_nettype none
module lcg_src_mux (
  input  wire logic [7:0] sources,
  input  wire logic [2:0] code,
  output var  logic       data_out
);
  always_comb begin
    data_out = sources[code];
  end
endmodule // lcg_src_mux
`default_nettype wire

// ---- logic/lcg_gate_or.sv ----
// one gate: or of the selected true and negated data input forms
// assumes select byte ordered in4 true at bit 7 to in1 negated at bit 0
`timescale 1ns/100ps
`default_nettype none
module lcg_gate_or (
  input  wire logic [3:0] data_in,
  input  wire logic [7:0] select,
  output var  logic       gate_out
);
  logic [7:0] forms;
  always_comb begin
    forms = {data_in[3], ~data_in[3], data_in[2], ~data_in[2],
             data_in[1], ~data_in[1], data_in[0], ~data_in[0]};
    gate_out = |(forms & select);
  end
endmodule // lcg_gate_or
`default_nettype wire

// ---- logic/lcg_top.sv ----
// gate-select stage of a configurable logic cell with wishbone registers
// assumes cell_input_source pins asynchronous; rst is a non power-on reset
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module lcg_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output var  logic        wb_ack_o,
  input  wire logic [7:0]  cell_input_source,
  output var  logic [3:0]  gate_sig,
  output var  logic [3:0]  data_in,
  output var  logic        cell_enable_bit,
  output var  logic [2:0]  cell_function_select,
  output var  logic [7:0]  logic_cell_polarity
);

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  logic [7:0] src_meta_r;
  logic [7:0] src_sync_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_meta_r <= 8'h00;
      src_sync_r <= 8'h00;
    end else begin
      src_meta_r <= cell_input_source;
      src_sync_r <= src_meta_r;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]        control_r;
  logic [7:0]        polarity_r;
  logic [7:0]        src_one_r;
  logic [7:0]        src_two_r;
  logic [3:0][7:0]   gate_sel_r;
  lcg_pkg::lcg_bus_state_type bus_state_r;
  lcg_pkg::lcg_bus_state_type bus_state_nxt;
  logic              req;
  logic              wr_take;
  logic [7:0]        wr_byte;
  logic [31:0]       rd_nxt;

  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_take = req && wb_we_i && (bus_state_r == lcg_pkg::LCG_IDLE) && wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control_r  <= lcg_pkg::LCG_CTRL_RESET;
      polarity_r <= lcg_pkg::LCG_POL_RESET;
      src_one_r  <= lcg_pkg::LCG_SRC_RESET;
      src_two_r  <= lcg_pkg::LCG_SRC_RESET;
    end else if (wr_take) begin
      if (wb_adr_i == lcg_pkg::LCG_ADDR_CONTROL) begin
        control_r <= wr_byte & lcg_pkg::LCG_CTRL_MASK;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_POLARITY) begin
        polarity_r <= wr_byte & lcg_pkg::LCG_POL_MASK;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_SRC_ONE) begin
        src_one_r <= wr_byte & lcg_pkg::LCG_SEL_MASK;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_SRC_TWO) begin
        src_two_r <= wr_byte & lcg_pkg::LCG_SEL_MASK;
      end
    end
  end

  // gate selects keep their value through rst; power-on value is unknown
  always_ff @(posedge clock) begin
    if (wr_take) begin
      if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_ONE) begin
        gate_sel_r[0] <= wr_byte;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_TWO) begin
        gate_sel_r[1] <= wr_byte;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_THR) begin
        gate_sel_r[2] <= wr_byte;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_FOU) begin
        gate_sel_r[3] <= wr_byte;
      end
    end
  end

  // ****************************************************************
  // gate select written flags, read by the checks only
  // ****************************************************************
  logic [3:0] sel_known_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_known_r <= 4'h0;
    end else if (wr_take) begin
      if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_ONE) begin
        sel_known_r[0] <= 1'b1;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_TWO) begin
        sel_known_r[1] <= 1'b1;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_THR) begin
        sel_known_r[2] <= 1'b1;
      end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_FOU) begin
        sel_known_r[3] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // data path
  // ****************************************************************
  logic [3:0] data_c;
  logic [3:0] gate_c;
  logic [3:0][2:0] codes;

  assign codes[0] = src_one_r[lcg_pkg::LCG_SEL_LO_POS +: lcg_pkg::LCG_SEL_W];
  assign codes[1] = src_one_r[lcg_pkg::LCG_SEL_HI_POS +: lcg_pkg::LCG_SEL_W];
  assign codes[2] = src_two_r[lcg_pkg::LCG_SEL_LO_POS +: lcg_pkg::LCG_SEL_W];
  assign codes[3] = src_two_r[lcg_pkg::LCG_SEL_HI_POS +: lcg_pkg::LCG_SEL_W];

  genvar gi;
  generate
    for (gi = 0; gi < lcg_pkg::LCG_NUM_GATES; gi++) begin : g_lane
      lcg_src_mux u_mux (
        .sources  (src_sync_r),
        .code     (codes[gi]),
        .data_out (data_c[gi])
      );
      lcg_gate_or u_gate (
        .data_in  (data_c),
        .select   (gate_sel_r[gi]),
        .gate_out (gate_c[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_in  <= 4'h0;
      gate_sig <= 4'h0;
    end else begin
      data_in  <= data_c;
      gate_sig <= gate_c;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cell_enable_bit      <= 1'b0;
      cell_function_select <= 3'h0;
      logic_cell_polarity  <= 8'h00;
    end else begin
      cell_enable_bit      <= control_r[lcg_pkg::LCG_CTRL_EN_POS];
      cell_function_select <= control_r[lcg_pkg::LCG_CTRL_FN_W-1:0];
      logic_cell_polarity  <= polarity_r;
    end
  end

  // ****************************************************************
  // wishbone slave: ack one cycle after request, then drop
  // ****************************************************************
  lcg_pkg::lcg_status_type status;
  assign status.gate = gate_sig;
  assign status.data = data_in;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == lcg_pkg::LCG_ADDR_CONTROL) begin
      rd_nxt[7:0] = control_r;
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_POLARITY) begin
      rd_nxt[7:0] = polarity_r;
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_SRC_ONE) begin
      rd_nxt[7:0] = src_one_r;
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_SRC_TWO) begin
      rd_nxt[7:0] = src_two_r;
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_ONE) begin
      rd_nxt[7:0] = gate_sel_r[0];
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_TWO) begin
      rd_nxt[7:0] = gate_sel_r[1];
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_THR) begin
      rd_nxt[7:0] = gate_sel_r[2];
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_FOU) begin
      rd_nxt[7:0] = gate_sel_r[3];
    end else if (wb_adr_i == lcg_pkg::LCG_ADDR_STATUS) begin
      rd_nxt[7:0] = status;
    end
  end

  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      lcg_pkg::LCG_IDLE: if (req) bus_state_nxt = lcg_pkg::LCG_ACK;
      lcg_pkg::LCG_ACK:  bus_state_nxt = lcg_pkg::LCG_IDLE;
      default:           bus_state_nxt = lcg_pkg::LCG_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_state_r <= lcg_pkg::LCG_IDLE;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      wb_ack_o    <= (bus_state_r == lcg_pkg::LCG_IDLE) && req;
      if ((bus_state_r == lcg_pkg::LCG_IDLE) && req) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_gate_one_or : assert property (@(posedge clock) disable iff (rst)
    $past(sel_known_r[0]) |-> gate_sig[0] == $past(|({data_c[3], ~data_c[3], data_c[2],
      ~data_c[2], data_c[1], ~data_c[1], data_c[0], ~data_c[0]} & gate_sel_r[0])))
    else $error("gate one mismatch");
  a_gate_two_none : assert property (@(posedge clock) disable iff (rst)
    (gate_sel_r[1] == 8'h00) |=> (gate_sig[1] == 1'b0))
    else $error("gate two not zero");
  a_gate_three_all : assert property (@(posedge clock) disable iff (rst)
    (gate_sel_r[2][1:0] == 2'b11) |=> gate_sig[2])
    else $error("gate three not one");
  a_gate_four_tru : assert property (@(posedge clock) disable iff (rst)
    (gate_sel_r[3] == 8'h80) |=> (gate_sig[3] == $past(data_c[3])))
    else $error("gate four wrong");
  a_sel_kept_rst : assert property (@(posedge clock)
    ($rose(rst) && ($past(sel_known_r) == 4'hf)) |=> $stable(gate_sel_r))
    else $error("gate select lost on reset");
  a_pol_zero_bits : assert property (@(posedge clock) disable iff (rst)
    (polarity_r[6:4] == 3'h0) && (src_one_r[7] == 1'b0) && (src_two_r[3] == 1'b0))
    else $error("unimplemented bit set");
  a_mux_index : assert property (@(posedge clock) disable iff (rst)
    ##1 data_in[0] == $past(src_sync_r[src_one_r[2:0]]))
    else $error("data mux wrong");
  a_ack_pulse : assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_req : assert property (@(posedge clock) disable iff (rst)
    (req && (bus_state_r == lcg_pkg::LCG_IDLE)) |=> wb_ack_o)
    else $error("request not acknowledged");
  a_dat_upper_zero : assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
    else $error("read data upper bits set");

  a_gate_two_or : assert property (@(posedge clock) disable iff (rst)
    $past(sel_known_r[1]) |-> gate_sig[1] == $past(|({data_c[3], ~data_c[3], data_c[2],
      ~data_c[2], data_c[1], ~data_c[1], data_c[0], ~data_c[0]} & gate_sel_r[1])))
    else $error("gate two mismatch");
  a_gate_thr_or : assert property (@(posedge clock) disable iff (rst)
    $past(sel_known_r[2]) |-> gate_sig[2] == $past(|({data_c[3], ~data_c[3], data_c[2],
      ~data_c[2], data_c[1], ~data_c[1], data_c[0], ~data_c[0]} & gate_sel_r[2])))
    else $error("gate three mismatch");
  a_gate_fou_or : assert property (@(posedge clock) disable iff (rst)
    $past(sel_known_r[3]) |-> gate_sig[3] == $past(|({data_c[3], ~data_c[3], data_c[2],
      ~data_c[2], data_c[1], ~data_c[1], data_c[0], ~data_c[0]} & gate_sel_r[3])))
    else $error("gate four mismatch");
  a_mux_two_index : assert property (@(posedge clock) disable iff (rst)
    ##1 data_in[1] == $past(src_sync_r[src_one_r[6:4]]))
    else $error("data two mux wrong");
  a_mux_thr_index : assert property (@(posedge clock) disable iff (rst)
    ##1 data_in[2] == $past(src_sync_r[src_two_r[2:0]]))
    else $error("data three mux wrong");
  a_mux_fou_index : assert property (@(posedge clock) disable iff (rst)
    ##1 data_in[3] == $past(src_sync_r[src_two_r[6:4]]))
    else $error("data four mux wrong");

  // ****************************************************************
  // checks: register writes and copies
  // ****************************************************************
  a_sel_one_write : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_ONE)) |=> (gate_sel_r[0] == $past(wr_byte)))
    else $error("gate one select not written");
  a_sel_two_write : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_TWO)) |=> (gate_sel_r[1] == $past(wr_byte)))
    else $error("gate two select not written");
  a_sel_thr_write : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_THR)) |=> (gate_sel_r[2] == $past(wr_byte)))
    else $error("gate three select not written");
  a_sel_fou_write : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_GATE_FOU)) |=> (gate_sel_r[3] == $past(wr_byte)))
    else $error("gate four select not written");
  a_pol_write_mask : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_POLARITY)) |=>
      (polarity_r == ($past(wr_byte) & lcg_pkg::LCG_POL_MASK)))
    else $error("polarity write not masked");
  a_src_one_mask : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_SRC_ONE)) |=>
      (src_one_r == ($past(wr_byte) & lcg_pkg::LCG_SEL_MASK)))
    else $error("source one write not masked");
  a_src_two_mask : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_SRC_TWO)) |=>
      (src_two_r == ($past(wr_byte) & lcg_pkg::LCG_SEL_MASK)))
    else $error("source two write not masked");
  a_ctrl_write_mask : assert property (@(posedge clock) disable iff (rst)
    (wr_take && (wb_adr_i == lcg_pkg::LCG_ADDR_CONTROL)) |=>
      (control_r == ($past(wr_byte) & lcg_pkg::LCG_CTRL_MASK)))
    else $error("control write not masked");
  a_pol_copy_out : assert property (@(posedge clock) disable iff (rst)
    ##1 logic_cell_polarity == $past(polarity_r))
    else $error("polarity output wrong");
  a_ctrl_copy_out : assert property (@(posedge clock) disable iff (rst)
    ##1 {cell_enable_bit, cell_function_select} ==
      $past({control_r[lcg_pkg::LCG_CTRL_EN_POS], control_r[lcg_pkg::LCG_CTRL_FN_W-1:0]}))
    else $error("control outputs wrong");

endmodule // lcg_top
`default_nettype wire

// ---- tb/lcg_top_bench.sv ----
// self-checking bench for the logic cell gate-select stage
// assumes lcg_top with one-cycle wishbone ack and a three-edge source path
`timescale 1ns/100ps
`default_nettype none
module lcg_top_bench;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clock;
  logic        rst;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_we_i;
  logic [3:0]  wb_sel_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_ack_o;
  logic [7:0]  cell_input_source;
  logic [3:0]  gate_sig;
  logic [3:0]  data_in;
  logic        cell_enable_bit;
  logic [2:0]  cell_function_select;
  logic [7:0]  logic_cell_polarity;
  logic [31:0] rdat;
  logic [7:0]  sel_r [4];
  logic [3:0]  gexp;
  integer      seed;
  int          miscompares;
  int          comparisons;
  int          cycles;

  lcg_top uut (
    .clock                (clock),
    .rst                  (rst),
    .wb_adr_i             (wb_adr_i),
    .wb_dat_i             (wb_dat_i),
    .wb_dat_o             (wb_dat_o),
    .wb_we_i              (wb_we_i),
    .wb_sel_i             (wb_sel_i),
    .wb_cyc_i             (wb_cyc_i),
    .wb_stb_i             (wb_stb_i),
    .wb_ack_o             (wb_ack_o),
    .cell_input_source    (cell_input_source),
    .gate_sig             (gate_sig),
    .data_in              (data_in),
    .cell_enable_bit      (cell_enable_bit),
    .cell_function_select (cell_function_select),
    .logic_cell_polarity  (logic_cell_polarity)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  always #2 clock = ~clock;

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; holds until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= s;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  function automatic logic gate_exp(input logic [3:0] d, input logic [7:0] s);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++) r = r | (s[2*i+1] & d[i]) | (s[2*i] & ~d[i]);
    return r;
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] adr_t [3];
    logic [7:0] msk_t [3];
    logic [7:0] src;
    adr_t = '{lcg_pkg::LCG_ADDR_POLARITY, lcg_pkg::LCG_ADDR_SRC_ONE, lcg_pkg::LCG_ADDR_SRC_TWO};
    msk_t = '{lcg_pkg::LCG_POL_MASK, lcg_pkg::LCG_SEL_MASK, lcg_pkg::LCG_SEL_MASK};
    clock = 1'b0;
    rst = 1'b1;
    {wb_adr_i, wb_dat_i, wb_we_i, wb_sel_i, wb_cyc_i, wb_stb_i} = '0;
    cell_input_source = 8'h00;
    seed = 32'h0e04;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, adr_t[k], 8'hff, 4'hf);
      bus(1'b0, adr_t[k], 8'h00, 4'hf);
      check("masked readback", rdat, {24'h000000, msk_t[k]});
    end
    bus(1'b1, lcg_pkg::LCG_ADDR_POLARITY, 8'h00, 4'he);
    bus(1'b0, lcg_pkg::LCG_ADDR_POLARITY, 8'h00, 4'hf);
    check("polarity kept", rdat, {24'h000000, lcg_pkg::LCG_POL_MASK});
    check("polarity out", logic_cell_polarity, {24'h000000, lcg_pkg::LCG_POL_MASK});
    bus(1'b1, 8'h24, 8'hff, 4'hf);
    bus(1'b0, 8'h24, 8'h00, 4'hf);
    check("unmapped", rdat, 32'h00000000);
    bus(1'b1, lcg_pkg::LCG_ADDR_CONTROL, 8'hff, 4'hf);
    bus(1'b0, lcg_pkg::LCG_ADDR_CONTROL, 8'h00, 4'hf);
    check("control", rdat, {24'h000000, lcg_pkg::LCG_CTRL_MASK});
    check("enable and mode", {cell_enable_bit, cell_function_select}, 4'hf);
    // every source code on all four data inputs
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, lcg_pkg::LCG_ADDR_SRC_ONE, {1'b0, c[2:0], 1'b0, c[2:0]}, 4'hf);
      bus(1'b1, lcg_pkg::LCG_ADDR_SRC_TWO, {1'b0, c[2:0], 1'b0, c[2:0]}, 4'hf);
      for (int j = 0; j < 3; j++) begin
        src = (j == 0) ? (8'h01 << c) : (j == 1) ? ~(8'h01 << c) : 8'($random(seed));
        cell_input_source <= src;
        repeat (5) @(posedge clock);
        check("data inputs", data_in, {4{src[c]}});
      end
    end
    // inputs one to four from sources 0 to 3; gate selects 00, ff, 80, then random
    bus(1'b1, lcg_pkg::LCG_ADDR_SRC_ONE, 8'h10, 4'hf);
    bus(1'b1, lcg_pkg::LCG_ADDR_SRC_TWO, 8'h32, 4'hf);
    for (int it = 0; it < 24; it++) begin
      for (int g = 0; g < 4; g++) begin
        sel_r[g] = (it == 0) ? 8'h00 : (it == 1) ? 8'hff : (it == 2) ? 8'h80 : 8'($random(seed));
        bus(1'b1, lcg_pkg::LCG_ADDR_GATE_ONE + 8'(4 * g), sel_r[g], 4'hf);
        bus(1'b0, lcg_pkg::LCG_ADDR_GATE_ONE + 8'(4 * g), 8'h00, 4'hf);
        check("gate select", rdat, {24'h000000, sel_r[g]});
      end
      src = 8'($random(seed));
      cell_input_source <= src;
      repeat (5) @(posedge clock);
      for (int g = 0; g < 4; g++) gexp[g] = gate_exp(src[3:0], sel_r[g]);
      check("gate one", gate_sig[0], gexp[0]);
      check("gate two", gate_sig[1], gexp[1]);
      check("gate three", gate_sig[2], gexp[2]);
      check("gate four", gate_sig[3], gexp[3]);
      bus(1'b0, lcg_pkg::LCG_ADDR_STATUS, 8'h00, 4'hf);
      check("status", rdat, {24'h000000, gexp, src[3:0]});
    end
    // selects survive a mid-run reset
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int g = 0; g < 4; g++) begin
      bus(1'b0, lcg_pkg::LCG_ADDR_GATE_ONE + 8'(4 * g), 8'h00, 4'hf);
      check("select after reset", rdat, {24'h000000, sel_r[g]});
    end
    close_out();
  end
endmodule // lcg_top_bench
`default_nettype wire
